// ==== shared/psc_pkg.sv ====
// Package with constants and types for the power-on strap configuration
package psc_pkg;

  // ----------------------------------------
  // I/O port pair and register indexes
  // ----------------------------------------
  localparam logic [15:0] PSC_IO_INDEX_PORT = 16'h0022;
  localparam logic [15:0] PSC_IO_DATA_PORT = 16'h0023;
  localparam logic [7:0] PSC_IDX_STRAP_ZERO = 8'h4a;
  localparam logic [7:0] PSC_IDX_STRAP_ONE = 8'h4b;
  localparam logic [7:0] PSC_IDX_STRAP_TWO = 8'h4c;
  localparam logic [7:0] PSC_IDX_HOST_CLOCK = 8'h5f;
  localparam logic [7:0] PSC_INDEX_RESET = 8'h00;

  // ----------------------------------------
  // Strap pin numbers on the memory data bus
  // ----------------------------------------
  localparam int PSC_MD_WIDTH = 64;
  localparam int PSC_PIN_HCLK_B4 = 3;
  localparam int PSC_PIN_HCLK_B3 = 2;
  localparam int PSC_PIN_PCI_DIV = 4;
  localparam int PSC_PIN_SYNC = 5;
  localparam int PSC_PIN_PLL_LO = 6;
  localparam int PSC_PIN_PLL_HI = 7;
  localparam int PSC_PIN_RSV_LO = 10;
  localparam int PSC_PIN_RSV_HI = 13;
  localparam int PSC_PIN_PCI_DIV2 = 17;
  localparam int PSC_PIN_DOT_SRC = 20;
  localparam int PSC_PIN_HCLK_B0 = 24;
  localparam int PSC_PIN_HCLK_B1 = 25;
  localparam int PSC_PIN_HCLK_B2 = 26;
  localparam int PSC_PIN_CPU_MULT = 40;
  localparam int PSC_PIN_BUS_SEL = 44;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PSC_S0_PLL_LSB = 6;
  localparam int PSC_S0_BUS_SEL = 5;
  localparam int PSC_S0_PCI_DIV = 4;
  localparam int PSC_S0_SYNC = 2;
  localparam int PSC_S0_PCI_DIV2 = 0;
  localparam int PSC_S1_RSV_LSB = 2;
  localparam int PSC_S2_CPU_MULT = 7;
  localparam int PSC_S2_DOT_SRC = 4;
  localparam int PSC_HC_CODE_LSB = 3;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] PSC_REG_RESET = 8'h00;
  localparam int PSC_CLK_HZ = 40000000;
  localparam int PSC_RST_OUT_NS = 400;
  localparam int PSC_RST_OUT_CYC = (PSC_RST_OUT_NS * (PSC_CLK_HZ / 1000000)
                                    + 999) / 1000;
  localparam logic [7:0] PSC_RST_OUT_CNT = 8'(PSC_RST_OUT_CYC);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PSC_DIV4 = 2'h0,
    PSC_DIV3 = 2'h1,
    PSC_DIV2 = 2'h2
  } psc_pci_div_t;

  typedef struct packed {
    logic [1:0] pci_pll_range;
    psc_pci_div_t pci_div;
    logic mem_host_sync;
    logic local_bus_sel;
    logic cpu_mult_x2;
    logic dot_clock_internal;
    logic [4:0] host_clock_code;
  } psc_cfg_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } psc_io_req_t;

endpackage

// ==== rtl/psc_pin_sync.sv ====
// Three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/10ps
`default_nettype none
module psc_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit, take the new level only once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign pin_out = out_q;

endmodule // psc_pin_sync
`default_nettype wire

// ==== rtl/psc_strap_config.sv ====
// Power-on strap capture, indexed read-back and configuration outputs
//
// Operation
// - Straps read through index port 22h and data port 23h, first at 4Ah.
// - First register bits 7-6 hold pins 7,6: PCI clock PLL range.
// - PCI divisor: pin 4 low gives /4, else pin 17 picks /3 or /2.
// - First register bit 2 holds pin 5: memory/host clock sync.
// - First register bit 5 holds pin 44: ISA or local bus select.
// - Third register bit 7 holds pin 40: core clock multiplier x1/x2.
// - Third register bit 4 holds pin 20: dot clock pin direction.
// - Dot clock source bit is software writable; other straps read only.
// - Host clock register bits 7-3 hold pins 3,2,26,25,24 speed code.
// - Straps sampled continuously while reset input low; kept at release.
`timescale 1ns/10ps
`default_nettype none
module psc_strap_config (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Board pins
  input wire logic system_reset_input_n,
  input wire logic [psc_pkg::PSC_MD_WIDTH-1:0] memory_data_strap_pin,
  output logic system_reset_output_n,
  // I/O port access
  input wire psc_pkg::psc_io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  // Configuration to clock and bus logic
  output psc_pkg::psc_cfg_t cfg,
  output logic dot_clock_oe
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  localparam int SYNC_W = psc_pkg::PSC_MD_WIDTH + 1;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic [psc_pkg::PSC_MD_WIDTH-1:0] md;
  logic sys_rst_in_n;

  assign sync_in = {system_reset_input_n, memory_data_strap_pin};

  psc_pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(sync_in),
    .pin_out(sync_out)
  );

  assign md = sync_out[psc_pkg::PSC_MD_WIDTH-1:0];
  assign sys_rst_in_n = sync_out[psc_pkg::PSC_MD_WIDTH];

  // ----------------------------------------
  // Reset sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_HOLD,
    ST_RUN
  } psc_state_t;

  psc_state_t state_q;
  logic [7:0] hold_cnt_q;
  logic sampling;

  assign sampling = (state_q == ST_SAMPLE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_SAMPLE;
    end else if (!sys_rst_in_n) begin
      state_q <= ST_SAMPLE;
    end else begin
      unique case (state_q)
        ST_SAMPLE: begin
          state_q <= ST_HOLD;
        end
        ST_HOLD: begin
          if (hold_cnt_q == 8'h01) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Straps must stay put until the reset output rises
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_q <= psc_pkg::PSC_RST_OUT_CNT;
    end else if (state_q != ST_HOLD) begin
      hold_cnt_q <= psc_pkg::PSC_RST_OUT_CNT;
    end else begin
      hold_cnt_q <= hold_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_reset_output_n <= 1'b0;
    end else begin
      system_reset_output_n <= (state_q == ST_RUN) && sys_rst_in_n;
    end
  end

  // ----------------------------------------
  // Strap registers
  // ----------------------------------------
  logic [7:0] strap_capture_zero_q;
  logic [7:0] strap_capture_one_q;
  logic [7:0] strap_capture_two_q;
  logic [7:0] host_q;
  logic [7:0] index_q;
  logic idx_wr;
  logic data_wr;
  logic data_rd;
  logic idx_rd;

  assign idx_wr = io_req.wr && (io_req.addr == psc_pkg::PSC_IO_INDEX_PORT);
  assign data_wr = io_req.wr && (io_req.addr == psc_pkg::PSC_IO_DATA_PORT);
  assign idx_rd = io_req.rd && (io_req.addr == psc_pkg::PSC_IO_INDEX_PORT);
  assign data_rd = io_req.rd && (io_req.addr == psc_pkg::PSC_IO_DATA_PORT);

  // Continuous capture while reset input is low; frozen after release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_capture_zero_q <= psc_pkg::PSC_REG_RESET;
      strap_capture_one_q <= psc_pkg::PSC_REG_RESET;
      host_q <= psc_pkg::PSC_REG_RESET;
    end else if (sampling) begin
      strap_capture_zero_q <= psc_pkg::PSC_REG_RESET;
      strap_capture_zero_q[psc_pkg::PSC_S0_PLL_LSB +: 2] <=
        md[psc_pkg::PSC_PIN_PLL_HI:psc_pkg::PSC_PIN_PLL_LO];
      strap_capture_zero_q[psc_pkg::PSC_S0_BUS_SEL] <= md[psc_pkg::PSC_PIN_BUS_SEL];
      strap_capture_zero_q[psc_pkg::PSC_S0_PCI_DIV] <= md[psc_pkg::PSC_PIN_PCI_DIV];
      strap_capture_zero_q[psc_pkg::PSC_S0_SYNC] <= md[psc_pkg::PSC_PIN_SYNC];
      strap_capture_zero_q[psc_pkg::PSC_S0_PCI_DIV2] <=
        md[psc_pkg::PSC_PIN_PCI_DIV2];
      strap_capture_one_q <= psc_pkg::PSC_REG_RESET;
      strap_capture_one_q[psc_pkg::PSC_S1_RSV_LSB +: 4] <=
        md[psc_pkg::PSC_PIN_RSV_HI:psc_pkg::PSC_PIN_RSV_LO];
      host_q <= psc_pkg::PSC_REG_RESET;
      host_q[psc_pkg::PSC_HC_CODE_LSB +: 5] <= {
        md[psc_pkg::PSC_PIN_HCLK_B4], md[psc_pkg::PSC_PIN_HCLK_B3],
        md[psc_pkg::PSC_PIN_HCLK_B2], md[psc_pkg::PSC_PIN_HCLK_B1],
        md[psc_pkg::PSC_PIN_HCLK_B0]};
    end
  end

  // Third register: sampled at reset, dot clock bit writable afterwards
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_capture_two_q <= psc_pkg::PSC_REG_RESET;
    end else if (sampling) begin
      strap_capture_two_q <= psc_pkg::PSC_REG_RESET;
      strap_capture_two_q[psc_pkg::PSC_S2_CPU_MULT] <=
        md[psc_pkg::PSC_PIN_CPU_MULT];
      strap_capture_two_q[psc_pkg::PSC_S2_DOT_SRC] <= md[psc_pkg::PSC_PIN_DOT_SRC];
    end else if (data_wr && (index_q == psc_pkg::PSC_IDX_STRAP_TWO)) begin
      strap_capture_two_q[psc_pkg::PSC_S2_DOT_SRC] <=
        io_req.wdata[psc_pkg::PSC_S2_DOT_SRC];
    end
  end

  // ----------------------------------------
  // Index/data port
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= psc_pkg::PSC_INDEX_RESET;
    end else if (idx_wr) begin
      index_q <= io_req.wdata;
    end
  end

  function automatic logic [7:0] read_strap(input logic [7:0] idx,
                                            input logic [7:0] s0,
                                            input logic [7:0] s1,
                                            input logic [7:0] s2,
                                            input logic [7:0] hc);
    logic [7:0] val;
    val = 8'h00;
    unique case (idx)
      psc_pkg::PSC_IDX_STRAP_ZERO: val = s0;
      psc_pkg::PSC_IDX_STRAP_ONE: val = s1;
      psc_pkg::PSC_IDX_STRAP_TWO: val = s2;
      psc_pkg::PSC_IDX_HOST_CLOCK: val = hc;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // One cycle read answer; unmapped indexes read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= idx_rd || data_rd;
      if (idx_rd) begin
        io_rdata <= index_q;
      end else if (data_rd) begin
        io_rdata <= read_strap(index_q, strap_capture_zero_q, strap_capture_one_q, strap_capture_two_q,
                               host_q);
      end
    end
  end

  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  psc_pkg::psc_pci_div_t pci_div;

  always_comb begin
    if (!strap_capture_zero_q[psc_pkg::PSC_S0_PCI_DIV]) begin
      pci_div = psc_pkg::PSC_DIV4;
    end else if (strap_capture_zero_q[psc_pkg::PSC_S0_PCI_DIV2]) begin
      pci_div = psc_pkg::PSC_DIV2;
    end else begin
      pci_div = psc_pkg::PSC_DIV3;
    end
  end

  always_comb begin
    cfg.pci_pll_range = strap_capture_zero_q[psc_pkg::PSC_S0_PLL_LSB +: 2];
    cfg.pci_div = pci_div;
    cfg.mem_host_sync = strap_capture_zero_q[psc_pkg::PSC_S0_SYNC];
    cfg.local_bus_sel = strap_capture_zero_q[psc_pkg::PSC_S0_BUS_SEL];
    cfg.cpu_mult_x2 = strap_capture_two_q[psc_pkg::PSC_S2_CPU_MULT];
    cfg.dot_clock_internal = strap_capture_two_q[psc_pkg::PSC_S2_DOT_SRC];
    cfg.host_clock_code = host_q[psc_pkg::PSC_HC_CODE_LSB +: 5];
  end

  assign dot_clock_oe = strap_capture_two_q[psc_pkg::PSC_S2_DOT_SRC];

endmodule // psc_strap_config
`default_nettype wire

// ==== testbench/psc_strap_config_props.sv ====
// Port assertions for the strap configuration block
`timescale 1ns/10ps
`default_nettype none
module psc_strap_config_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Board pins
  input wire logic system_reset_input_n,
  input wire logic [63:0] memory_data_strap_pin,
  input wire logic system_reset_output_n,
  // I/O port and configuration
  input wire psc_pkg::psc_io_req_t io_req,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire psc_pkg::psc_cfg_t cfg,
  input wire logic dot_clock_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic [63:0] p = memory_data_strap_pin;
  wire logic io_hit = io_req.rd &&
      (io_req.addr == psc_pkg::PSC_IO_INDEX_PORT ||
       io_req.addr == psc_pkg::PSC_IO_DATA_PORT);
  // Straps settled while sampling
  sequence s_set;
    (!system_reset_input_n && $stable(p))[*8];
  endsequence
  a_rd_answer: assert property (io_hit |=> io_rvalid)
    else $error("read at port pair not answered");
  a_rd_ignore: assert property (!io_hit |=> !io_rvalid)
    else $error("answer without a read");
  a_pll_follow: assert property (s_set |-> cfg.pci_pll_range == p[7:6])
    else $error("pll range differs from straps");
  a_div_map: assert property (s_set |-> cfg.pci_div == (p[4] ?
      (p[17] ? psc_pkg::PSC_DIV2 : psc_pkg::PSC_DIV3) : psc_pkg::PSC_DIV4))
    else $error("pci divisor wrong");
  a_bus_fields: assert property (s_set |->
      {cfg.mem_host_sync, cfg.local_bus_sel, cfg.cpu_mult_x2} ==
      {p[5], p[44], p[40]})
    else $error("sync, bus or multiplier wrong");
  a_dot_dir: assert property (s_set |->
      {cfg.dot_clock_internal, dot_clock_oe} == {2{p[20]}})
    else $error("dot clock direction wrong");
  a_host_code: assert property (s_set |->
      cfg.host_clock_code == {p[3], p[2], p[26], p[25], p[24]})
    else $error("host clock code wrong");
  a_strap_frozen: assert property (system_reset_output_n ##1
      !$stable({cfg[12:6], cfg[4:0]}) |-> ##[0:2] !system_reset_output_n)
    else $error("straps changed after release");
  a_rstout_hold: assert property ($rose(system_reset_output_n) |->
      $past(system_reset_input_n, 17))
    else $error("reset output rose too early");
  a_rstout_fall: assert property (!system_reset_input_n |->
      ##[0:5] !system_reset_output_n)
    else $error("reset output stayed high");
endmodule // psc_strap_config_props
`default_nettype wire

// ==== testbench/psc_board_straps.sv ====
// Board strap resistors and memory bus traffic model
`timescale 1ns/10ps
`default_nettype none
module psc_board_straps (
  // Clock and reset output of the device
  input wire logic ref_clk,
  input wire logic system_reset_output_n,
  // User straps and pin levels
  input wire logic [63:0] user_straps,
  output logic [63:0] memory_data_strap_pin
);
  localparam logic [63:0] USER = 64'h0000_1100_0712_307c;
  localparam logic [63:0] PULL_UP = 64'h0001_4400_00ed_4002;
  localparam logic [63:0] PULL_DN = 64'h0000_aa00_7800_0c80;
  logic [63:0] drift_q = 64'h5a5a_5a5a_5a5a_5a5a;
  // Unpulled lines wander with bus traffic, rest while reset output low
  always @(posedge ref_clk) begin
    if (system_reset_output_n === 1'b1) begin
      drift_q <= ~drift_q;
    end
  end
  // Straps held until reset output rises, then bus traffic
  assign memory_data_strap_pin = system_reset_output_n ? drift_q :
      (user_straps & USER) | PULL_UP |
      (drift_q & ~(USER | PULL_UP | PULL_DN));
endmodule // psc_board_straps
`default_nettype wire

// ==== testbench/psc_strap_config_tb_top.sv ====
// Self-checking bench for the strap configuration block
`timescale 1ns/10ps
`default_nettype none
module psc_strap_config_tb_top;
  typedef struct {logic [63:0] u; logic [7:0] r [4];} psc_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic system_reset_input_n = 1'b0;
  logic [63:0] user_straps = '0;
  logic [63:0] memory_data_strap_pin;
  logic system_reset_output_n;
  psc_pkg::psc_io_req_t io_req = '0;
  logic [7:0] io_rdata;
  logic io_rvalid;
  psc_pkg::psc_cfg_t cfg;
  logic dot_clock_oe;
  int miscompares = 0;
  int checks = 0;
  logic [7:0] idx [4] = '{psc_pkg::PSC_IDX_STRAP_ZERO,
      psc_pkg::PSC_IDX_STRAP_ONE, psc_pkg::PSC_IDX_STRAP_TWO,
      psc_pkg::PSC_IDX_HOST_CLOCK};
  psc_row_t rows [4] = '{
      '{64'h0000_0000_0000_0000, '{8'h00, 8'h00, 8'h00, 8'h00}},
      '{64'hffff_ffff_ffff_ffff, '{8'h75, 8'h30, 8'h90, 8'hf8}},
      '{64'h0000_0100_0300_1018, '{8'h10, 8'h10, 8'h80, 8'h98}},
      '{64'h0000_0000_0102_204c, '{8'h41, 8'h20, 8'h00, 8'hc8}}};

  psc_strap_config dut (.ref_clk, .rst_n, .system_reset_input_n,
      .memory_data_strap_pin, .system_reset_output_n, .io_req, .io_rdata,
      .io_rvalid, .cfg, .dot_clock_oe);
  psc_board_straps u_board (.ref_clk, .system_reset_output_n,
      .user_straps, .memory_data_strap_pin);

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic acc(input logic [15:0] a, input logic w, logic [7:0] d);
    @(posedge ref_clk) io_req <= '{addr: a, rd: !w, wr: w, wdata: d};
    @(posedge ref_clk) io_req <= '0;
  endtask

  task automatic put(input logic [7:0] i, d);
    acc(psc_pkg::PSC_IO_INDEX_PORT, 1'b1, i);
    acc(psc_pkg::PSC_IO_DATA_PORT, 1'b1, d);
  endtask

  task automatic get(input string n, input logic [7:0] i, e);
    acc(psc_pkg::PSC_IO_INDEX_PORT, 1'b1, i);
    acc(psc_pkg::PSC_IO_DATA_PORT, 1'b0, 8'h00);
    #1 chk({n, " valid"}, 8'h01, {7'h0, io_rvalid});
    chk(n, e, io_rdata);
  endtask

  task automatic boot(input logic [63:0] u);
    @(posedge ref_clk) system_reset_input_n <= 1'b0;
    user_straps <= u;
    repeat (16) @(posedge ref_clk);
    system_reset_input_n <= 1'b1;
    for (int i = 0; i < 40 && system_reset_output_n !== 1'b1; i++)
      @(posedge ref_clk);
    #1 chk("reset out", 8'h01, {7'h0, system_reset_output_n});
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[r]) begin
      boot(rows[r].u);
      foreach (idx[k]) get("strap reg", idx[k], rows[r].r[k]);
    end
    // ----------------------------------------
    // Hand-written cases
    // ----------------------------------------
    put(psc_pkg::PSC_IDX_STRAP_TWO, 8'hff);
    get("dot write", psc_pkg::PSC_IDX_STRAP_TWO, 8'h10);
    chk("dot oe", 8'h01, {7'h0, dot_clock_oe});
    put(psc_pkg::PSC_IDX_STRAP_ZERO, 8'hff);
    get("ro write", psc_pkg::PSC_IDX_STRAP_ZERO, 8'h41);
    get("unmapped", 8'h50, 8'h00);
    acc(psc_pkg::PSC_IO_INDEX_PORT, 1'b0, 8'h00);
    #1 chk("index read", 8'h50, io_rdata);
    acc(16'h0024, 1'b0, 8'h00);
    #1 chk("other port", 8'h00, {7'h0, io_rvalid});
    boot(rows[0].u);
    get("resample", psc_pkg::PSC_IDX_STRAP_TWO, rows[0].r[2]);
    @(posedge ref_clk) rst_n <= 1'b0;
    #1 chk("reset low", 8'h00, {7'h0, system_reset_output_n});
    @(posedge ref_clk) rst_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk("after reset", 8'h00, {7'h0, system_reset_output_n});
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end
endmodule // psc_strap_config_tb_top

bind psc_strap_config psc_strap_config_props u_props (.ref_clk, .rst_n,
    .system_reset_input_n, .memory_data_strap_pin, .system_reset_output_n,
    .io_req, .io_rdata, .io_rvalid, .cfg, .dot_clock_oe);
`default_nettype wire
